//--- include/rds_pkg.sv
package rds_pkg;
    // ------------------------------------------------------------
    // Frame format
    // ------------------------------------------------------------
    localparam int FRAME_BITS = 8;
    localparam int CNT_W = 3;
    localparam logic [2:0] CNT_ZERO = 3'h0;
    localparam int CMD_WRITE_BIT = 7;
    localparam int CMD_STD_DIAG_BIT = 1;
    localparam int CMD_BANK_BIT = 0;
    localparam int ADDR_HI = 6;
    localparam int ADDR_LO = 4;
    // ------------------------------------------------------------
    // Register addresses and fields
    // ------------------------------------------------------------
    localparam logic [2:0] CTRL_POWER_ADDR = 3'h0;
    localparam logic [1:0] DIAG_LOAD_ADDR = 2'h0;
    localparam int CTRL_WAKE_BIT = 3;
    localparam int CTRL_STANDBY_BIT = 2;
    localparam int CTRL_RESET_BIT = 1;
    localparam int CTRL_PROT_BIT = 0;
    localparam int DIAG_OL_B_BIT = 3;
    localparam int DIAG_FAULT_B_BIT = 2;
    localparam int DIAG_OL_A_BIT = 1;
    localparam int DIAG_FAULT_A_BIT = 0;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [3:0] CTRL_RESET_VAL = 4'h0;
    localparam logic [3:0] DIAG_RESET_VAL = 4'h0;
    localparam logic [7:0] TX_RESET_VAL = 8'h00;
    localparam logic TER_RESET_VAL = 1'b1;
endpackage

//--- rtl/rds_link.sv
module rds_link (
    input wire logic srst_i,
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic si_i,
    input wire logic [7:0] tx_word_i,
    output logic [7:0] rx_word_o,
    output logic [2:0] bit_cnt_o,
    output logic frame_tog_o,
    output logic so_o
);
    logic started_reg;
    logic [7:0] shift_reg;
    logic [2:0] cnt_reg;
    logic tog_reg;
    logic so_reg;
    logic [7:0] shift_src;

    // ------------------------------------------------------------
    // Frame start flag, cleared while chip select is high
    // ------------------------------------------------------------
    always_ff @(negedge sclk_i or posedge cs_n_i or posedge srst_i) begin
        if (cs_n_i || srst_i) begin
            started_reg <= 1'b0;
        end else begin
            started_reg <= 1'b1;
        end
    end

    assign shift_src = started_reg ? shift_reg : tx_word_i;

    // ------------------------------------------------------------
    // Capture on falling clock, MSB first
    // ------------------------------------------------------------
    always_ff @(negedge sclk_i or posedge srst_i) begin
        if (srst_i) begin
            shift_reg <= rds_pkg::TX_RESET_VAL;
            cnt_reg <= rds_pkg::CNT_ZERO;
            tog_reg <= 1'b0;
        end else if (!cs_n_i) begin
            shift_reg <= {shift_src[6:0], si_i};
            cnt_reg <= started_reg ? cnt_reg + 3'h1 : 3'h1;
            if (!started_reg) begin
                tog_reg <= ~tog_reg;
            end
        end
    end

    // ------------------------------------------------------------
    // Output on rising clock
    // ------------------------------------------------------------
    always_ff @(posedge sclk_i or posedge srst_i) begin
        if (srst_i) begin
            so_reg <= 1'b0;
        end else if (!cs_n_i) begin
            so_reg <= started_reg ? shift_reg[7] : tx_word_i[7];
        end
    end

    assign rx_word_o = shift_reg;
    assign bit_cnt_o = cnt_reg;
    assign frame_tog_o = tog_reg;
    assign so_o = so_reg;

    a_bit_count: assert property (@(negedge sclk_i) disable iff (srst_i || cs_n_i)
        started_reg |=> cnt_reg == $past(cnt_reg) + 3'h1)
        else $error("bit counter did not advance");
    a_so_first: assert property (@(posedge sclk_i) disable iff (srst_i || cs_n_i)
        !started_reg |=> so_reg == $past(tx_word_i[7]))
        else $error("first output bit is not the MSB");
    c_daisy: cover property (@(negedge sclk_i) disable iff (srst_i || cs_n_i)
        started_reg && cnt_reg == 3'h7 ##1 cnt_reg == 3'h0);
endmodule // rds_link

//--- rtl/rds_top.sv
// Function
// - Act only as a full-duplex serial slave with in, out, clock, select.
// - Falling chip select starts a new access.
// - Serial input bits are captured on falling serial clock edges.
// - Serial output advances to the next bit on rising clock edges.
// - Count clocks modulo 8; accept data only for whole multiples of 8.
// - Shifted-in bits pass on to serial output for daisy chaining.
// - Reset returns all interface state and registers to defaults.
// - Diagnosis bits 3 and 1 are read-only sticky open-load flags.
// - Control register: wake bit 3, standby 2, reset control 1, config 0.
// - While select is high, ignore clock and input; output is high impedance.
// - Bad frame length sets the transmission error flag and drops command.
// - Data moves MSB first in 8-bit frames of control and data parts.
// - Read needs two frames; contents appear during the second frame.
module rds_top #(
    parameter logic [3:0] CTRL_RESET = rds_pkg::CTRL_RESET_VAL
) (
    input wire logic sys_clk_i,
    input wire logic srst_i,
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic si_i,
    input wire logic fault_flag_ch_a_i,
    input wire logic fault_flag_ch_b_i,
    input wire logic open_load_flag_ch_a_i,
    input wire logic open_load_flag_ch_b_i,
    input wire logic limp_home_i,
    output logic so_o,
    output logic so_oe_o,
    output logic wake_request_o,
    output logic standby_request_o,
    output logic reset_ctrl_o,
    output logic protection_config_bit_o,
    output logic ter_o
);
    logic [7:0] rx_word;
    logic [2:0] bit_cnt;
    logic frame_tog;
    logic [7:0] tx_word_reg;
    logic [7:0] tx_word_next;
    logic cs_meta_reg;
    logic cs_sync_reg;
    logic cs_prev_reg;
    logic tog_meta_reg;
    logic tog_sync_reg;
    logic tog_seen_reg;
    logic so_oe_reg;
    logic ter_reg;
    logic [3:0] ctrl_mem [0:7];
    logic [3:0] diag_reg;
    logic frame_end;
    logic frame_ok;
    logic is_write;
    logic is_std;
    logic diag_clr;
    logic [2:0] addr;

    // ------------------------------------------------------------
    // Serial link
    // ------------------------------------------------------------
    rds_link u_link (
        .srst_i(srst_i),
        .sclk_i(sclk_i),
        .cs_n_i(cs_n_i),
        .si_i(si_i),
        .tx_word_i(tx_word_reg),
        .rx_word_o(rx_word),
        .bit_cnt_o(bit_cnt),
        .frame_tog_o(frame_tog),
        .so_o(so_o)
    );

    // ------------------------------------------------------------
    // Synchronisers and frame end detection
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            cs_meta_reg <= 1'b1;
            cs_sync_reg <= 1'b1;
            cs_prev_reg <= 1'b1;
            tog_meta_reg <= 1'b0;
            tog_sync_reg <= 1'b0;
        end else begin
            cs_meta_reg <= cs_n_i;
            cs_sync_reg <= cs_meta_reg;
            cs_prev_reg <= cs_sync_reg;
            tog_meta_reg <= frame_tog;
            tog_sync_reg <= tog_meta_reg;
        end
    end

    assign frame_end = cs_sync_reg && !cs_prev_reg;
    assign frame_ok = (bit_cnt == rds_pkg::CNT_ZERO) && (tog_sync_reg != tog_seen_reg);
    assign is_write = rx_word[rds_pkg::CMD_WRITE_BIT];
    assign is_std = rx_word[rds_pkg::CMD_STD_DIAG_BIT];
    assign addr = rx_word[rds_pkg::ADDR_HI:rds_pkg::ADDR_LO];

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            tog_seen_reg <= 1'b0;
        end else if (frame_end) begin
            tog_seen_reg <= tog_sync_reg;
        end
    end

    // ------------------------------------------------------------
    // Output enable and transmission error
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            so_oe_reg <= 1'b0;
        end else begin
            so_oe_reg <= !cs_sync_reg;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            ter_reg <= rds_pkg::TER_RESET_VAL;
        end else if (frame_end) begin
            ter_reg <= !frame_ok;
        end
    end

    // ------------------------------------------------------------
    // Control bank
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            for (int i = 0; i < 8; i++) begin
                ctrl_mem[i] <= CTRL_RESET;
            end
        end else if (frame_end && frame_ok && is_write) begin
            ctrl_mem[addr] <= rx_word[3:0];
        end
    end

    // ------------------------------------------------------------
    // Diagnosis register, sticky flags, cleared when read out
    // ------------------------------------------------------------
    assign diag_clr = frame_end && frame_ok && !is_write && !is_std
        && rx_word[rds_pkg::CMD_BANK_BIT] && addr[1:0] == rds_pkg::DIAG_LOAD_ADDR;

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            diag_reg <= rds_pkg::DIAG_RESET_VAL;
        end else begin
            diag_reg[rds_pkg::DIAG_OL_B_BIT] <= open_load_flag_ch_b_i
                || (diag_reg[rds_pkg::DIAG_OL_B_BIT] && !diag_clr);
            diag_reg[rds_pkg::DIAG_FAULT_B_BIT] <= fault_flag_ch_b_i
                || (diag_reg[rds_pkg::DIAG_FAULT_B_BIT] && !diag_clr);
            diag_reg[rds_pkg::DIAG_OL_A_BIT] <= open_load_flag_ch_a_i
                || (diag_reg[rds_pkg::DIAG_OL_A_BIT] && !diag_clr);
            diag_reg[rds_pkg::DIAG_FAULT_A_BIT] <= fault_flag_ch_a_i
                || (diag_reg[rds_pkg::DIAG_FAULT_A_BIT] && !diag_clr);
        end
    end

    // ------------------------------------------------------------
    // Answer word for the next frame
    // ------------------------------------------------------------
    always_comb begin
        tx_word_next = {2'h0, ctrl_mem[rds_pkg::CTRL_POWER_ADDR][rds_pkg::CTRL_WAKE_BIT],
            limp_home_i, 2'h0, diag_reg[rds_pkg::DIAG_FAULT_B_BIT],
            diag_reg[rds_pkg::DIAG_FAULT_A_BIT]};
        if (!is_write && !is_std) begin
            if (rx_word[rds_pkg::CMD_BANK_BIT]) begin
                tx_word_next = {2'h1, addr[1:0],
                    (addr[1:0] == rds_pkg::DIAG_LOAD_ADDR) ? diag_reg : 4'h0};
            end else begin
                tx_word_next = {1'b1, addr, ctrl_mem[addr]};
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            tx_word_reg <= rds_pkg::TX_RESET_VAL;
        end else if (frame_end) begin
            tx_word_reg <= frame_ok ? tx_word_next : tx_word_reg;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            wake_request_o <= CTRL_RESET[rds_pkg::CTRL_WAKE_BIT];
            standby_request_o <= CTRL_RESET[rds_pkg::CTRL_STANDBY_BIT];
            reset_ctrl_o <= CTRL_RESET[rds_pkg::CTRL_RESET_BIT];
            protection_config_bit_o <= CTRL_RESET[rds_pkg::CTRL_PROT_BIT];
        end else begin
            wake_request_o <= ctrl_mem[rds_pkg::CTRL_POWER_ADDR][rds_pkg::CTRL_WAKE_BIT];
            standby_request_o <= ctrl_mem[rds_pkg::CTRL_POWER_ADDR][rds_pkg::CTRL_STANDBY_BIT];
            reset_ctrl_o <= ctrl_mem[rds_pkg::CTRL_POWER_ADDR][rds_pkg::CTRL_RESET_BIT];
            protection_config_bit_o <= ctrl_mem[rds_pkg::CTRL_POWER_ADDR][rds_pkg::CTRL_PROT_BIT];
        end
    end

    assign so_oe_o = so_oe_reg;
    assign ter_o = ter_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_ter_on_error: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        frame_end && !frame_ok |=> ter_reg)
        else $error("error flag not set on bad frame");
    a_ter_on_good: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        frame_end && frame_ok |=> !ter_reg)
        else $error("error flag not cleared on good frame");
    a_oe_idle: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        cs_sync_reg |=> !so_oe_o)
        else $error("output driven while deselected");
    a_ctrl_write: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        frame_end && frame_ok && is_write && addr == rds_pkg::CTRL_POWER_ADDR
        |-> ##2 {wake_request_o, standby_request_o, reset_ctrl_o, protection_config_bit_o}
            == $past(rx_word[3:0], 2))
        else $error("control write not applied");
    a_bad_no_write: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        frame_end && !frame_ok |=> $stable(ctrl_mem[rds_pkg::CTRL_POWER_ADDR]))
        else $error("bad frame changed control");
    a_reset_default: assert property (@(posedge sys_clk_i)
        srst_i |=> ter_reg && tx_word_reg == rds_pkg::TX_RESET_VAL && !so_oe_o)
        else $error("reset defaults not restored");
    a_ol_sticky: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        open_load_flag_ch_a_i ##1 !open_load_flag_ch_a_i && !diag_clr
        |-> diag_reg[rds_pkg::DIAG_OL_A_BIT])
        else $error("open load flag lost");
    a_read_answer: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        frame_end && frame_ok && !is_write && !is_std && !rx_word[rds_pkg::CMD_BANK_BIT]
        |=> tx_word_reg == {1'b1, $past(addr), $past(ctrl_mem[addr])})
        else $error("read answer wrong");
    c_good_frame: cover property (@(posedge sys_clk_i) frame_end && frame_ok && is_write);
    c_bad_frame: cover property (@(posedge sys_clk_i) frame_end && !frame_ok);
    c_diag_read: cover property (@(posedge sys_clk_i) diag_clr);
endmodule // rds_top

//--- verification/rds_host_model.sv
module rds_host_model (
    input wire logic so_i,
    input wire logic so_oe_i,
    output logic sclk_o,
    output logic cs_n_o,
    output logic si_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic last;
    logic line;
    logic oe_miss;
    // Released line shows the inverse of its last level
    assign line = so_oe_i ? so_i : ~last;
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        si_o = 1'b0;
        last = 1'b0;
        oe_miss = 1'b0;
    end
    // ----------------------------------------
    // Frame of n bits, clock low at select edges
    // ----------------------------------------
    task automatic frame(input logic [15:0] tx, input int n, output logic [15:0] rx);
        rx = 16'h0000;
        oe_miss = 1'b0;
        cs_n_o = 1'b0;
        #150;
        for (int k = n - 1; k >= 0; k--) begin
            si_o = tx[k];
            #16;
            sclk_o = 1'b1;
            #32;
            sclk_o = 1'b0;
            rx = {rx[14:0], line};
            last = line;
            if (so_oe_i !== 1'b1) oe_miss = 1'b1;
            #16;
        end
        cs_n_o = 1'b1;
        si_o = ~si_o;
        #200;
    endtask
    // ----------------------------------------
    // Clock and data noise while deselected
    // ----------------------------------------
    task automatic idle_noise();
        for (int k = 0; k < 9; k++) begin
            si_o = k[0];
            #32;
            sclk_o = 1'b1;
            #32;
            sclk_o = 1'b0;
        end
        #200;
    endtask
endmodule // rds_host_model

//--- verification/rds_bench.sv
module rds_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic sys_clk = 1'b0;
    logic srst = 1'b0;
    logic fa = 1'b0;
    logic fb = 1'b0;
    logic oa = 1'b0;
    logic ob = 1'b0;
    logic limp = 1'b1;
    logic sclk;
    logic cs_n;
    logic si;
    logic so;
    logic so_oe;
    logic wake;
    logic stby;
    logic rstc;
    logic prot;
    logic ter;
    logic [3:0] ctrl;
    logic [7:0] rx;
    int fail_count = 0;
    int n_compared = 0;
    assign ctrl = {wake, stby, rstc, prot};
    always #12.5 sys_clk = ~sys_clk;
    rds_top i_rds_top (.sys_clk_i(sys_clk), .srst_i(srst), .sclk_i(sclk), .cs_n_i(cs_n),
        .si_i(si), .fault_flag_ch_a_i(fa), .fault_flag_ch_b_i(fb),
        .open_load_flag_ch_a_i(oa), .open_load_flag_ch_b_i(ob), .limp_home_i(limp),
        .so_o(so), .so_oe_o(so_oe), .wake_request_o(wake), .standby_request_o(stby),
        .reset_ctrl_o(rstc), .protection_config_bit_o(prot), .ter_o(ter));
    rds_host_model i_rds_host_model (.so_i(so), .so_oe_i(so_oe), .sclk_o(sclk),
        .cs_n_o(cs_n), .si_o(si));
    // ----------------------------------------
    // Shared helpers
    // ----------------------------------------
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic xfer(input logic [15:0] tx, input int n, output logic [7:0] r);
        logic [15:0] r16;
        i_rds_host_model.frame(tx, n, r16);
        r = r16[7:0];
    endtask
    task automatic complete_run();
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic test_defaults();
        check("ter", {7'h00, rds_pkg::TER_RESET_VAL}, {7'h00, ter});
        check("ctrl", {4'h0, rds_pkg::CTRL_RESET_VAL}, {4'h0, ctrl});
        check("so_oe", 8'h00, {7'h00, so_oe});
    endtask
    task automatic test_ctrl_bits();
        for (int k = 0; k < 4; k++) begin
            xfer({8'h00, 4'h8, 4'h1 << k}, 8, rx);
            check("ctrl", {4'h0, 4'h1 << k}, {4'h0, ctrl});
            check("ter", 8'h00, {7'h00, ter});
            check("oe gap", 8'h00, {7'h00, i_rds_host_model.oe_miss});
        end
        xfer(16'h0000, 8, rx);
        xfer(16'h0089, 8, rx);
        check("ctrl read", 8'h88, rx);
        check("ctrl", 8'h09, {4'h0, ctrl});
        xfer(16'h00d5, 8, rx);
        check("ctrl", 8'h09, {4'h0, ctrl});
        xfer(16'h0050, 8, rx);
        xfer(16'h0002, 8, rx);
        check("ctrl read", 8'hd5, rx);
    endtask
    task automatic test_bad_length();
        xfer(16'h0080, 7, rx);
        check("ter", 8'h01, {7'h00, ter});
        check("ctrl", 8'h09, {4'h0, ctrl});
        xfer(16'h0180, 9, rx);
        check("ter", 8'h01, {7'h00, ter});
        check("ctrl", 8'h09, {4'h0, ctrl});
        xfer(16'h008c, 8, rx);
        check("ter", 8'h00, {7'h00, ter});
        check("ctrl", 8'h0c, {4'h0, ctrl});
    endtask
    task automatic test_daisy();
        xfer(16'h8f00, 16, rx);
        check("passed byte", 8'h8f, rx);
        check("ctrl", 8'h0c, {4'h0, ctrl});
        check("ter", 8'h00, {7'h00, ter});
        xfer(16'h0002, 8, rx);
        check("ctrl read", 8'h8c, rx);
        xfer(16'h0002, 8, rx);
        check("std diag", 8'h30, rx);
    endtask
    task automatic test_diag();
        @(negedge sys_clk);
        ob <= 1'b1;
        oa <= 1'b1;
        fa <= 1'b1;
        limp <= 1'b0;
        @(negedge sys_clk);
        ob <= 1'b0;
        oa <= 1'b0;
        fa <= 1'b0;
        xfer(16'h0002, 8, rx);
        check("std diag", 8'h30, rx);
        xfer(16'h0001, 8, rx);
        check("std diag", 8'h21, rx);
        xfer(16'h0001, 8, rx);
        check("diag read", 8'h4b, rx);
        xfer(16'h0011, 8, rx);
        check("diag cleared", 8'h40, rx);
        xfer(16'h0002, 8, rx);
        check("diag addr 1", 8'h50, rx);
    endtask
    task automatic test_cs_high();
        i_rds_host_model.idle_noise();
        check("ctrl", 8'h0c, {4'h0, ctrl});
        check("ter", 8'h00, {7'h00, ter});
        check("so_oe", 8'h00, {7'h00, so_oe});
    endtask
    task automatic test_mid_reset();
        @(negedge sys_clk);
        srst <= 1'b1;
        repeat (2) @(negedge sys_clk);
        srst <= 1'b0;
        repeat (4) @(negedge sys_clk);
        test_defaults();
        xfer(16'h0000, 8, rx);
        check("answer after reset", 8'h00, rx);
        xfer(16'h0002, 8, rx);
        check("ctrl read", 8'h80, rx);
    endtask
    initial begin
        srst <= 1'b1;
        repeat (8) @(negedge sys_clk);
        srst <= 1'b0;
        repeat (4) @(negedge sys_clk);
        test_defaults();
        test_ctrl_bits();
        test_bad_length();
        test_daisy();
        test_diag();
        test_cs_high();
        test_mid_reset();
        complete_run();
    end
    initial begin
        #100000;
        fail_count++;
        complete_run();
    end
endmodule // rds_bench
